/* tvc_regs.sv */
`timescale 1ns/1ns
module tvc_regs
	import tvc_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYCLES
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// register port
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	output logic                      reg_rvalid,
	// system state from other register groups
	input  wire logic [2:0]           power_state_select,
	input  wire logic                 pin_function_select,
	input  wire logic [1:0]           clock_mode,
	input  wire logic [3:0]           slave_clock_multiplier,
	// analog sense interface
	input  wire logic                 luma_above_pin,
	input  wire logic                 chroma_above_pin,
	input  wire logic                 composite_above_pin,
	output logic                      sense_current_en,
	output logic                      sync_suppress,
	output logic                      sense_done,
	// luma path
	input  wire logic [LUMA_W-1:0]    luma_in,
	input  wire logic                 luma_in_valid,
	output logic      [LUMA_W-1:0]    luma_out,
	output logic                      luma_out_valid,
	// pll divider values
	output logic      [REF_DIV_W-1:0] pll_ref_div,
	output logic      [FB_DIV_W-1:0]  pll_fb_div,
	output logic      [FB_DIV_W-1:0]  pll_mult_term,
	output logic      [FB_DIV_W-1:0]  pll_div_term,
	// shared clock / data start pin
	input  wire logic                 crystal_pin,
	input  wire logic                 field_id,
	input  wire logic                 shared_pin_in,
	output logic                      shared_pin_out,
	output logic                      shared_pin_oe_n,
	output logic                      data_start
);
	import tvc_pkg::*;

	// register storage
	logic [GAIN_W-1:0]    contrast_gain;
	logic [DIV_MSB_W-1:0] div_msb;
	logic [7:0]           ref_low;
	logic [7:0]           fb_low;
	logic [CLK_SEL_W-1:0] clk_sel;
	logic                 luma_open_flag;
	logic                 chroma_open_flag;
	logic                 composite_open_flag;

	// synchronisers
	logic [2:0] cmp_meta;
	logic [2:0] cmp_sync;
	logic       xtal_meta;
	logic       xtal_sync;
	logic       pin_meta;
	logic       pin_sync;

	// sense sequence
	tvc_state_t                   state;
	logic [$clog2(SETTLE+1)-1:0]  settle_cnt;
	logic                         wr_detect;
	logic                         power_normal;

	// clock output
	logic [2:0]        clock_source_select;
	logic [2:0]        post_divide_select;
	logic [HALF_W-1:0] output_divisor;
	logic              osc_div;
	logic              next_pin_out;

	// contrast
	logic [LUMA_W-1:0] next_luma;

	function automatic logic [5:0] gain_num(input logic [2:0] code);
		case (code)
			3'h0:    gain_num = NUM_5_4;
			3'h1:    gain_num = NUM_9_8;
			3'h2:    gain_num = NUM_17_16;
			3'h4:    gain_num = NUM_17_16;
			3'h5:    gain_num = NUM_9_8;
			3'h6:    gain_num = NUM_5_4;
			3'h7:    gain_num = NUM_3_2;
			default: gain_num = NUM_UNITY;
		endcase
	endfunction : gain_num

	function automatic logic [2:0] gain_shr(input logic [2:0] code);
		case (code)
			3'h0:    gain_shr = SHR_4;
			3'h1:    gain_shr = SHR_8;
			3'h2:    gain_shr = SHR_16;
			3'h4:    gain_shr = SHR_16;
			3'h5:    gain_shr = SHR_8;
			3'h6:    gain_shr = SHR_4;
			3'h7:    gain_shr = SHR_2;
			default: gain_shr = SHR_1;
		endcase
	endfunction : gain_shr

	function automatic logic [7:0] gain_off(input logic [2:0] code);
		case (code)
			3'h0:    gain_off = BLACK_OFF_3;
			3'h1:    gain_off = BLACK_OFF_2;
			3'h2:    gain_off = BLACK_OFF_1;
			default: gain_off = 8'h00;
		endcase
	endfunction : gain_off

	function automatic logic [HALF_W-1:0] half_divisor(input logic [2:0] code);
		case (code)
			3'h0:    half_divisor = HALF_2P5;
			3'h2:    half_divisor = HALF_3P5;
			3'h3:    half_divisor = HALF_4P0;
			3'h4:    half_divisor = HALF_4P5;
			3'h5:    half_divisor = HALF_5P0;
			3'h6:    half_divisor = HALF_6P0;
			3'h7:    half_divisor = HALF_7P0;
			default: half_divisor = HALF_OFF;
		endcase
	endfunction : half_divisor

	assign wr_detect    = reg_wr && (reg_addr == ADDR_DETECT);
	assign power_normal = (power_state_select == POWER_NORMAL);

	// register writes; reserved overflow bits are plain storage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			contrast_gain <= RST_CONTRAST;
			div_msb       <= RST_DIV_MSB;
			ref_low       <= RST_REF_LOW;
			fb_low        <= RST_FB_LOW;
			clk_sel       <= RST_CLK_SEL;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_CONTRAST: contrast_gain <= reg_wdata[GAIN_W-1:0];
				ADDR_DIV_MSB:  div_msb       <= reg_wdata[DIV_MSB_W-1:0];
				ADDR_REF_LOW:  ref_low       <= reg_wdata;
				ADDR_FB_LOW:   fb_low        <= reg_wdata;
				ADDR_CLK_SEL:  clk_sel       <= reg_wdata[CLK_SEL_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// register reads
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			reg_rdata  <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					ADDR_DETECT: begin
						// trigger bit is write-only and reads zero
						reg_rdata[BIT_LUMA_OPEN]   <= luma_open_flag;
						reg_rdata[BIT_CHROMA_OPEN] <= chroma_open_flag;
						reg_rdata[BIT_COMP_OPEN]   <= composite_open_flag;
					end
					ADDR_CONTRAST: reg_rdata <= {{(8-GAIN_W){1'b0}}, contrast_gain};
					ADDR_DIV_MSB:  reg_rdata <= {{(8-DIV_MSB_W){1'b0}}, div_msb};
					ADDR_REF_LOW:  reg_rdata <= ref_low;
					ADDR_FB_LOW:   reg_rdata <= fb_low;
					ADDR_CLK_SEL:  reg_rdata <= {{(8-CLK_SEL_W){1'b0}}, clk_sel};
					default:       reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// comparator pins, crystal pin and shared pin
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmp_meta  <= 3'h0;
			cmp_sync  <= 3'h0;
			xtal_meta <= 1'b0;
			xtal_sync <= 1'b0;
			pin_meta  <= 1'b0;
			pin_sync  <= 1'b0;
		end else begin
			cmp_meta  <= {luma_above_pin, chroma_above_pin, composite_above_pin};
			cmp_sync  <= cmp_meta;
			xtal_meta <= crystal_pin;
			xtal_sync <= xtal_meta;
			pin_meta  <= shared_pin_in;
			pin_sync  <= pin_meta;
		end
	end

	// sense sequence
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state      <= TVC_IDLE;
			settle_cnt <= '0;
		end else begin
			case (state)
				TVC_IDLE: begin
					if (wr_detect && reg_wdata[BIT_TRIGGER] && power_normal) begin
						state <= TVC_SENSING;
					end
				end
				TVC_SENSING: begin
					if (wr_detect && !reg_wdata[BIT_TRIGGER]) begin
						state      <= TVC_SETTLE;
						settle_cnt <= '0;
					end
				end
				TVC_SETTLE: begin
					// let the levels pass the synchroniser and settle
					if (settle_cnt == ($clog2(SETTLE+1))'(SETTLE)) begin
						state <= TVC_IDLE;
					end else begin
						settle_cnt <= settle_cnt + 1'b1;
					end
				end
				default: state <= TVC_IDLE;
			endcase
		end
	end

	// analog controls during sensing
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sense_current_en <= 1'b0;
			sync_suppress    <= 1'b0;
		end else begin
			sense_current_en <= (state == TVC_SENSING);
			sync_suppress    <= (state == TVC_SENSING);
		end
	end

	// open flags: above threshold means no load attached
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			luma_open_flag      <= 1'b0;
			chroma_open_flag    <= 1'b0;
			composite_open_flag <= 1'b0;
			sense_done          <= 1'b0;
		end else begin
			if (state == TVC_SETTLE && settle_cnt == ($clog2(SETTLE+1))'(SETTLE)) begin
				luma_open_flag      <= cmp_sync[2];
				chroma_open_flag    <= cmp_sync[1];
				composite_open_flag <= cmp_sync[0];
				sense_done          <= 1'b1;
			end else if (state == TVC_SENSING) begin
				sense_done <= 1'b0;
			end
		end
	end

	// contrast curve
	always_comb begin
		logic signed [16:0] diff;
		logic signed [16:0] prod;
		logic signed [16:0] scaled;
		// full width before the product so bright inputs cannot wrap
		diff   = $signed({9'h000, luma_in}) - $signed({9'h000, gain_off(contrast_gain)});
		prod   = diff * $signed({11'h000, gain_num(contrast_gain)});
		scaled = prod >>> gain_shr(contrast_gain);
		if (scaled < 0) begin
			next_luma = 8'h00;
		end else if (scaled > $signed({9'h000, LUMA_MAX})) begin
			next_luma = LUMA_MAX;
		end else begin
			next_luma = scaled[LUMA_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			luma_out       <= '0;
			luma_out_valid <= 1'b0;
		end else begin
			luma_out_valid <= luma_in_valid;
			if (luma_in_valid) begin
				luma_out <= next_luma;
			end
		end
	end

	// pll divider values
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pll_ref_div   <= {RST_DIV_MSB[BIT_REF_MSB], RST_REF_LOW};
			pll_fb_div    <= {RST_DIV_MSB[BIT_FB_B9], RST_DIV_MSB[BIT_FB_B8], RST_FB_LOW};
			pll_mult_term <= '0;
			pll_div_term  <= '0;
		end else begin
			if (clock_mode == MODE_SLAVE) begin
				pll_ref_div <= {{(REF_DIV_W-4){1'b0}}, slave_clock_multiplier};
				pll_fb_div  <= SLAVE_FB;
			end else begin
				pll_ref_div <= {div_msb[BIT_REF_MSB], ref_low};
				pll_fb_div  <= {div_msb[BIT_FB_B9], div_msb[BIT_FB_B8], fb_low};
			end
			// master and pseudo-master ratio terms (N+2) and (M+2)
			pll_mult_term <= {div_msb[BIT_FB_B9], div_msb[BIT_FB_B8], fb_low} + DIV_BIAS;
			pll_div_term  <= {1'b0, div_msb[BIT_REF_MSB], ref_low} + DIV_BIAS;
		end
	end

	// buffered clock output
	assign clock_source_select = clk_sel[SRC_LSB +: 3];
	assign post_divide_select  = clk_sel[SHIFT_LSB +: 3];
	assign output_divisor      = (post_divide_select == SHF_RESERVED) ? HALF_OFF
		: half_divisor(post_divide_select);

	tvc_half_div #(
		.W (HALF_W)
	) u_half_div (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.half_div (output_divisor),
		.div_out  (osc_div)
	);

	always_comb begin
		case (clock_source_select)
			SRC_CRYSTAL:  next_pin_out = xtal_sync;
			SRC_OSC_DIV:  next_pin_out = osc_div;
			SRC_FIELD_ID: next_pin_out = field_id;
			default:      next_pin_out = 1'b0; // test selections stay quiet
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shared_pin_out  <= 1'b0;
			shared_pin_oe_n <= 1'b1;
			data_start      <= 1'b0;
		end else begin
			shared_pin_out  <= pin_function_select ? 1'b0 : next_pin_out;
			shared_pin_oe_n <= pin_function_select;
			data_start      <= pin_function_select ? pin_sync : 1'b0;
		end
	end

endmodule : tvc_regs

/* tvc_pkg.sv */
package tvc_pkg;

	// register offsets on the programming port
	localparam logic [7:0] ADDR_DETECT   = 8'h10;
	localparam logic [7:0] ADDR_CONTRAST = 8'h11;
	localparam logic [7:0] ADDR_DIV_MSB  = 8'h13;
	localparam logic [7:0] ADDR_REF_LOW  = 8'h14;
	localparam logic [7:0] ADDR_FB_LOW   = 8'h15;
	localparam logic [7:0] ADDR_CLK_SEL  = 8'h17;

	// reset values
	localparam logic [7:0] RST_DETECT   = 8'h00;
	localparam logic [2:0] RST_CONTRAST = 3'h3;
	localparam logic [4:0] RST_DIV_MSB  = 5'h00;
	localparam logic [7:0] RST_REF_LOW  = 8'h41;
	localparam logic [7:0] RST_FB_LOW   = 8'h80;
	localparam logic [5:0] RST_CLK_SEL  = 6'h00;

	// connection detect field positions
	localparam int BIT_TRIGGER     = 0;
	localparam int BIT_COMP_OPEN   = 1;
	localparam int BIT_CHROMA_OPEN = 2;
	localparam int BIT_LUMA_OPEN   = 3;

	// divider overflow field positions
	localparam int BIT_REF_MSB = 0;
	localparam int BIT_FB_B8   = 1;
	localparam int BIT_FB_B9   = 2;
	localparam int DIV_MSB_W   = 5;

	// clock output select field positions
	localparam int SRC_LSB   = 0;
	localparam int SHIFT_LSB = 3;
	localparam int CLK_SEL_W = 6;

	// widths
	localparam int REF_DIV_W = 9;
	localparam int FB_DIV_W  = 10;
	localparam int GAIN_W    = 3;
	localparam int LUMA_W    = 8;
	localparam int HALF_W    = 4;

	// power state encoding that allows sensing
	localparam logic [2:0] POWER_NORMAL = 3'h3;

	// clock source codes
	localparam logic [2:0] SRC_CRYSTAL  = 3'h0;
	localparam logic [2:0] SRC_OSC_DIV  = 3'h2;
	localparam logic [2:0] SRC_FIELD_ID = 3'h3;

	// post divide codes, divisor given in half units
	localparam logic [2:0] SHF_RESERVED = 3'h1;
	localparam logic [3:0] HALF_2P5 = 4'h5;
	localparam logic [3:0] HALF_3P5 = 4'h7;
	localparam logic [3:0] HALF_4P0 = 4'h8;
	localparam logic [3:0] HALF_4P5 = 4'h9;
	localparam logic [3:0] HALF_5P0 = 4'ha;
	localparam logic [3:0] HALF_6P0 = 4'hc;
	localparam logic [3:0] HALF_7P0 = 4'he;
	localparam logic [3:0] HALF_OFF = 4'h0;

	// contrast curve constants
	localparam logic [7:0] BLACK_OFF_3 = 8'h66;
	localparam logic [7:0] BLACK_OFF_2 = 8'h39;
	localparam logic [7:0] BLACK_OFF_1 = 8'h1e;
	localparam logic [5:0] NUM_5_4   = 6'h05;
	localparam logic [5:0] NUM_9_8   = 6'h09;
	localparam logic [5:0] NUM_17_16 = 6'h11;
	localparam logic [5:0] NUM_3_2   = 6'h03;
	localparam logic [5:0] NUM_UNITY = 6'h01;
	localparam logic [2:0] SHR_4  = 3'h2;
	localparam logic [2:0] SHR_8  = 3'h3;
	localparam logic [2:0] SHR_16 = 3'h4;
	localparam logic [2:0] SHR_2  = 3'h1;
	localparam logic [2:0] SHR_1  = 3'h0;
	localparam logic [7:0] LUMA_MAX = 8'hff;

	// clock mode encoding
	localparam logic [1:0] MODE_MASTER = 2'h0;
	localparam logic [1:0] MODE_PSEUDO = 2'h1;
	localparam logic [1:0] MODE_SLAVE  = 2'h2;
	localparam logic [9:0] SLAVE_FB    = 10'h001;
	localparam logic [9:0] DIV_BIAS    = 10'h002;

	// timing
	localparam int CLK_MHZ  = 250;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ) / 1000;

	typedef enum logic [1:0] {
		TVC_IDLE,
		TVC_SENSING,
		TVC_SETTLE
	} tvc_state_t;

endpackage : tvc_pkg

/* tvc_half_div.sv */
`timescale 1ns/1ns
// fractional divider: average output period is half_div/2 input cycles
module tvc_half_div #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// control
	input  wire logic [W-1:0] half_div,
	// output
	output logic              div_out
);
	logic [W+1:0] acc;
	logic [W+1:0] next_acc;
	logic         run;

	assign run = (half_div != '0);

	// four half units per cycle; toggling per wrap gives period half_div/2
	always_comb begin
		next_acc = acc + (W+2)'(4);
		if (next_acc >= {2'b00, half_div}) begin
			next_acc = next_acc - {2'b00, half_div};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !run) begin
			acc     <= '0;
			div_out <= 1'b0;
		end else begin
			acc <= next_acc;
			if ((acc + (W+2)'(4)) >= {2'b00, half_div}) begin
				div_out <= ~div_out;
			end
		end
	end

endmodule : tvc_half_div

/* tvc_regs_asserts.sv */
`timescale 1ns/1ns
module tvc_regs_asserts
	import tvc_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// register port
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	// system state
	input wire logic [2:0] power_state_select,
	input wire logic       pin_function_select,
	input wire logic [1:0] clock_mode,
	input wire logic [3:0] slave_clock_multiplier,
	// sense outputs, luma valids, pll and pin outputs
	input wire logic       sense_current_en,
	input wire logic       sync_suppress,
	input wire logic       sense_done,
	input wire logic       luma_in_valid,
	input wire logic       luma_out_valid,
	input wire logic [8:0] pll_ref_div,
	input wire logic [9:0] pll_fb_div,
	input wire logic [9:0] pll_mult_term,
	input wire logic [9:0] pll_div_term,
	input wire logic       shared_pin_oe_n,
	input wire logic       data_start
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_read_answer: assert property (reg_rvalid == $past(reg_rd))
		else $error("read valid not one cycle after read strobe");
	a_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
		else $error("read data not zero outside answer");
	a_luma_lag: assert property (luma_out_valid == $past(luma_in_valid))
		else $error("luma valid lag wrong");
	a_sense_pair: assert property (sense_current_en == sync_suppress)
		else $error("sense current and sync suppress differ");
	a_flags_hidden: assert property (sense_current_en |-> !sense_done)
		else $error("flags valid while sensing");
	a_sense_cause: assert property ($rose(sense_current_en) |-> $past(reg_wr, 2)
		&& $past(reg_addr, 2) == ADDR_DETECT && $past(reg_wdata[0], 2)
		&& $past(power_state_select, 2) == POWER_NORMAL)
		else $error("sensing started without trigger in normal power");
	a_slave_divs: assert property (!$past(sys_rst) && $past(clock_mode) == MODE_SLAVE
		|-> pll_ref_div == {5'h00, $past(slave_clock_multiplier)} && pll_fb_div == SLAVE_FB)
		else $error("slave mode divider values wrong");
	a_pll_terms: assert property (!$past(sys_rst) && $past(clock_mode) != MODE_SLAVE
		|-> pll_mult_term == pll_fb_div + DIV_BIAS
		&& pll_div_term == {1'b0, pll_ref_div} + DIV_BIAS)
		else $error("pll ratio terms wrong");
	a_pin_dir: assert property (!$past(sys_rst) |-> shared_pin_oe_n == $past(pin_function_select))
		else $error("shared pin direction wrong");
	a_start_off: assert property (!$past(sys_rst) && !$past(pin_function_select) |-> !data_start)
		else $error("data start active while pin is output");
endmodule : tvc_regs_asserts

bind tvc_regs tvc_regs_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .power_state_select(power_state_select),
	.pin_function_select(pin_function_select), .clock_mode(clock_mode),
	.slave_clock_multiplier(slave_clock_multiplier), .sense_current_en(sense_current_en),
	.sync_suppress(sync_suppress), .sense_done(sense_done), .luma_in_valid(luma_in_valid),
	.luma_out_valid(luma_out_valid), .pll_ref_div(pll_ref_div), .pll_fb_div(pll_fb_div),
	.pll_mult_term(pll_mult_term), .pll_div_term(pll_div_term),
	.shared_pin_oe_n(shared_pin_oe_n), .data_start(data_start));

/* tvc_host.sv */
`timescale 1ns/1ns
module tvc_host
	import tvc_pkg::*;
(
	// clock
	input wire logic       clk,
	// register port
	output logic           reg_wr,
	output logic           reg_rd,
	output logic     [7:0] reg_addr,
	output logic     [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= (a == ADDR_DIV_MSB) ? (d & 8'he7) : d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		v = reg_rvalid;
	endtask : rd
endmodule : tvc_host

/* tvc_regs_bench.sv */
`timescale 1ns/1ns
module tvc_regs_bench;
	import tvc_pkg::*;
	logic clk = 0, sys_rst = 1, reg_wr, reg_rd, reg_rvalid, pin_function_select = 0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, luma_in = 0, luma_out;
	logic [2:0] power_state_select = 3'h3;
	logic [1:0] clock_mode = 2'h0;
	logic [3:0] slave_clock_multiplier = 4'h0;
	logic luma_above_pin = 0, chroma_above_pin = 0, composite_above_pin = 0;
	logic sense_current_en, sync_suppress, sense_done, luma_in_valid = 0, luma_out_valid;
	logic [8:0] pll_ref_div;
	logic [9:0] pll_fb_div, pll_mult_term, pll_div_term;
	logic crystal_pin = 0, field_id = 0, shared_pin_in = 0;
	logic shared_pin_out, shared_pin_oe_n, data_start;
	int error_cnt = 0, compares = 0;

	always #2 clk = ~clk;

	tvc_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	tvc_regs #(.SETTLE(4)) dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .power_state_select(power_state_select),
		.pin_function_select(pin_function_select), .clock_mode(clock_mode),
		.slave_clock_multiplier(slave_clock_multiplier), .luma_above_pin(luma_above_pin),
		.chroma_above_pin(chroma_above_pin), .composite_above_pin(composite_above_pin),
		.sense_current_en(sense_current_en), .sync_suppress(sync_suppress),
		.sense_done(sense_done), .luma_in(luma_in), .luma_in_valid(luma_in_valid),
		.luma_out(luma_out), .luma_out_valid(luma_out_valid), .pll_ref_div(pll_ref_div),
		.pll_fb_div(pll_fb_div), .pll_mult_term(pll_mult_term), .pll_div_term(pll_div_term),
		.crystal_pin(crystal_pin), .field_id(field_id), .shared_pin_in(shared_pin_in),
		.shared_pin_out(shared_pin_out), .shared_pin_oe_n(shared_pin_oe_n),
		.data_start(data_start));

	task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_cnt(input int got, input int exp);
		compares++;
		if (got < exp - 1 || got > exp + 1) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_cnt

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run

	task automatic test_reset;
		logic [7:0] a[7] = '{8'h10, 8'h11, 8'h13, 8'h14, 8'h15, 8'h17, 8'h12};
		logic [7:0] e[7] = '{8'h00, 8'h03, 8'h00, 8'h41, 8'h80, 8'h00, 8'h00};
		logic [7:0] d;
		logic v;
		foreach (a[i]) begin
			host.rd(a[i], d, v);
			check_val(v, 1'b1);
			check_val(d, e[i]);
		end
		check_val(pll_ref_div, 10'h041);
		check_val(pll_fb_div, 10'h080);
		$display("test reset done");
	endtask : test_reset

	task automatic test_divs;
		logic [7:0] d;
		logic v;
		host.wr(8'h14, 8'h39);
		host.wr(8'h15, 8'h87);
		host.wr(8'h13, 8'h1d);
		repeat (3) @(posedge clk);
		#1;
		check_val(pll_ref_div, 10'd313);
		check_val(pll_fb_div, 10'd647);
		check_val(pll_mult_term, 10'd649);
		check_val(pll_div_term, 10'd315);
		host.rd(8'h13, d, v);
		check_val(d, 8'h05);
		@(posedge clk);
		clock_mode <= MODE_SLAVE;
		slave_clock_multiplier <= 4'h9;
		repeat (3) @(posedge clk);
		#1;
		check_val(pll_ref_div, 10'd9);
		check_val(pll_fb_div, 10'd1);
		@(posedge clk);
		clock_mode <= MODE_PSEUDO;
		repeat (3) @(posedge clk);
		#1;
		check_val(pll_ref_div, 10'd313);
		check_val(pll_fb_div, 10'd647);
		@(posedge clk);
		clock_mode <= MODE_MASTER;
		$display("test dividers done");
	endtask : test_divs

	task automatic test_sense;
		logic [7:0] d;
		logic v;
		logic [2:0] p;
		int n;
		@(posedge clk);
		power_state_select <= 3'h1;
		host.wr(8'h10, 8'h01);
		repeat (3) @(posedge clk);
		#1;
		check_val(sense_current_en, 1'b0);
		host.wr(8'h10, 8'h00);
		power_state_select <= POWER_NORMAL;
		for (int k = 0; k < 2; k++) begin
			p = k ? 3'b010 : 3'b101;
			{luma_above_pin, chroma_above_pin, composite_above_pin} <= p;
			host.wr(8'h10, 8'h01);
			@(posedge clk);
			#1;
			check_val({sense_current_en, sync_suppress, sense_done}, 3'b110);
			host.wr(8'h10, 8'h00);
			n = 0;
			while (sense_done !== 1'b1 && n < 50) begin
				@(posedge clk);
				n++;
			end
			host.rd(8'h10, d, v);
			check_val({sense_current_en, sense_done, d}, {2'b01, 4'h0, p, 1'b0});
		end
		$display("test sense done");
	endtask : test_sense

	task automatic test_luma;
		int off[8] = '{102, 57, 30, 0, 0, 0, 0, 0};
		int num[8] = '{5, 9, 17, 1, 17, 9, 5, 3};
		int shr[8] = '{2, 3, 4, 0, 4, 3, 2, 1};
		int ys[5] = '{0, 30, 100, 180, 255};
		int e;
		for (int c = 0; c < 8; c++) begin
			host.wr(8'h11, 8'(c));
			foreach (ys[i]) begin
				e = ((ys[i] - off[c]) * num[c]) >>> shr[c];
				e = e < 0 ? 0 : (e > 255 ? 255 : e);
				@(posedge clk);
				luma_in <= 8'(ys[i]);
				luma_in_valid <= 1'b1;
				@(posedge clk);
				luma_in_valid <= 1'b0;
				#1;
				check_val({1'b0, luma_out_valid, luma_out}, {2'b01, 8'(e)});
			end
		end
		$display("test luma done");
	endtask : test_luma

	task automatic test_clock;
		// source select, field id, crystal level, expected pin level
		logic [3:0] t[4] = '{4'b0111, 4'b0100, 4'b0011, 4'b1101};
		int half[8] = '{5, 0, 7, 8, 9, 10, 12, 14};
		int cnt;
		logic prev;
		foreach (t[i]) begin
			host.wr(8'h17, t[i][3] ? 8'h03 : 8'h00);
			field_id <= t[i][2];
			crystal_pin <= t[i][1];
			repeat (6) @(posedge clk);
			#1;
			check_val({shared_pin_oe_n, shared_pin_out}, {1'b0, t[i][0]});
		end
		for (int s = 0; s < 8; s++) begin
			host.wr(8'h17, {2'b00, 3'(s), 3'h2});
			repeat (20) @(posedge clk);
			#1;
			cnt = 0;
			prev = shared_pin_out;
			repeat (840) begin
				@(posedge clk);
				#1;
				if (shared_pin_out === 1'b1 && prev === 1'b0) cnt++;
				prev = shared_pin_out;
			end
			check_cnt(cnt, half[s] ? 1680 / half[s] : 0);
		end
		pin_function_select <= 1'b1;
		shared_pin_in <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		check_val({shared_pin_oe_n, data_start, shared_pin_out}, 3'b110);
		@(posedge clk);
		pin_function_select <= 1'b0;
		$display("test clock output done");
	endtask : test_clock

	// longest path is the divisor sweep, about 7000 cycles
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		complete_run();
	end

	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		test_reset();
		test_divs();
		test_sense();
		test_luma();
		test_clock();
		complete_run();
	end
endmodule : tvc_regs_bench
